// file: pkg/pte_pkg.sv
/*
  Constants for the event conditioning, interrupt flag and status block.
  Assumes a 250 MHz bus clock that also clocks the timer side.
*/
package pte_pkg;

  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SYNC_TIME_NS  = 12;
  localparam int unsigned SYNC_CYCLES   = (SYNC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SYNC_CNT_W    = 2;
  localparam int unsigned FILT_SAMPLES  = 4;

  localparam logic [7:0] IDX_EVT_A  = 8'h08;
  localparam logic [7:0] IDX_EVT_B  = 8'h09;
  localparam logic [7:0] IDX_INT_EN = 8'h0C;
  localparam logic [7:0] IDX_FLAGS  = 8'h0D;
  localparam logic [7:0] IDX_STATUS = 8'h0E;

  localparam logic [2:0] SEL_NONE   = 3'h0;
  localparam logic [2:0] SEL_EVT_A  = 3'h1;
  localparam logic [2:0] SEL_EVT_B  = 3'h2;
  localparam logic [2:0] SEL_INT_EN = 3'h3;
  localparam logic [2:0] SEL_FLAGS  = 3'h4;
  localparam logic [2:0] SEL_STATUS = 3'h5;

  localparam int unsigned CFG_LSB    = 6;
  localparam int unsigned EDGE_BIT   = 4;
  localparam int unsigned ACTION_BIT = 2;
  localparam int unsigned EVENT_TRIGGER_INPUT_ENABLE_BIT = 0;
  localparam logic [1:0]  CFG_NEITHER = 2'h0;
  localparam logic [1:0]  CFG_FILTER  = 2'h1;
  localparam logic [1:0]  CFG_ASYNC   = 2'h2;

  localparam int unsigned TRIGGER_B_IRQ_BIT  = 3;
  localparam int unsigned TRIGGER_A_IRQ_BIT  = 2;
  localparam int unsigned OVF_BIT    = 0;
  localparam int unsigned ACTB_BIT   = 7;
  localparam int unsigned ACTA_BIT   = 6;
  localparam int unsigned COMMAND_READY_BIT = 1;
  localparam int unsigned ENABLE_READY_BIT  = 0;

  localparam logic [7:0] EVT_MASK   = 8'hD5;
  localparam logic [7:0] INT_MASK   = 8'h0D;
  localparam logic [7:0] REG_RESET  = 8'h00;

  typedef enum logic [0:0] {
    PTE_IDLE = 1'b0,
    PTE_BUSY = 1'b1
  } pte_sync_st_t;

endpackage : pte_pkg

// file: design/pte_sync_track.sv
/*
  Tracks one crossing into the timer side and shows when it is done.
  Assumes start is a one-cycle pulse from the register logic.
*/
`timescale 1ns/1ps
module pte_sync_track
  import pte_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      ready,
  output logic      taken
);

  typedef struct packed {
    pte_sync_st_t          st;
    logic [SYNC_CNT_W-1:0] cnt;
    logic                  taken;
  } pte_trk_st_t;

  pte_trk_st_t cur_ff;
  pte_trk_st_t nxt_cur;

  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.taken = 1'b0;
    case (cur_ff.st)
      PTE_IDLE: begin
        if (start) begin
          nxt_cur.st    = PTE_BUSY;
          nxt_cur.cnt   = SYNC_CNT_W'(SYNC_CYCLES - 1);
          nxt_cur.taken = 1'b1;
        end
      end
      default: begin
        // Start while busy is dropped on purpose
        if (cur_ff.cnt != '0) begin // RL19
          nxt_cur.cnt = cur_ff.cnt - 1'b1;
        end else begin
          nxt_cur.st = PTE_IDLE; // RL22
        end
      end
    endcase
  end

  // Comes up busy so ready rises by itself after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '{st: PTE_BUSY, cnt: SYNC_CNT_W'(SYNC_CYCLES - 1), taken: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign ready = (cur_ff.st == PTE_IDLE);
  assign taken = cur_ff.taken;

  sequence s_busy;
    !ready [*3];
  endsequence

  property p_sync_gap;
    @(posedge pclk) disable iff (!presetn)
    (start && ready) |=> s_busy ##1 ready;
  endproperty
  a_sync_gap: assert property (p_sync_gap) else $error("ready gap wrong"); // RL22

  property p_busy_ignore;
    @(posedge pclk) disable iff (!presetn)
    (start && !ready) |=> !taken;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("start taken while busy"); // RL19

endmodule : pte_sync_track

// file: design/pte_evt_cond.sv
/*
  Conditions one event input: filter, edge or level select, action.
  Assumes event_in is already synchronous to pclk.
*/
`timescale 1ns/1ps
module pte_evt_cond
  import pte_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       event_in,
  input  wire logic [7:0] cfg,
  output logic            trigger,
  output logic            capture,
  output logic            fault,
  output logic            async_fault
);

  typedef struct packed {
    logic [FILT_SAMPLES-1:0] hist;
    logic                    lvl;
    logic                    filt;
    logic                    act_prev;
    logic                    trig;
    logic                    cap;
    logic                    fault;
  } pte_cond_st_t;

  pte_cond_st_t cur_ff;
  pte_cond_st_t nxt_cur;
  logic [1:0]   mode;
  logic         src;
  logic         act;
  logic         en;

  assign mode = cfg[CFG_LSB+1:CFG_LSB];
  assign en   = cfg[EVENT_TRIGGER_INPUT_ENABLE_BIT]; // RL8

  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.hist = {cur_ff.hist[FILT_SAMPLES-2:0], event_in};
    nxt_cur.lvl  = event_in;
    if (cur_ff.hist == '1) begin // RL1
      nxt_cur.filt = 1'b1;
    end else if (cur_ff.hist == '0) begin
      nxt_cur.filt = 1'b0;
    end
    // Reserved codes act as neither
    src = (mode == CFG_FILTER) ? cur_ff.filt : cur_ff.lvl; // RL4 RL2
    act = cfg[EDGE_BIT] ? src : !src; // RL5
    nxt_cur.act_prev = act;
    nxt_cur.fault    = en && act;
    nxt_cur.trig     = en && act && !cur_ff.act_prev;
    nxt_cur.cap      = en && act && !cur_ff.act_prev && cfg[ACTION_BIT]; // RL6
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign trigger = cur_ff.trig;
  assign capture = cur_ff.cap;
  assign fault   = cur_ff.fault;
  // Bypasses every flop so the output reacts within the cycle
  assign async_fault = en && (mode == CFG_ASYNC) &&
                       (cfg[EDGE_BIT] ? event_in : !event_in); // RL3

  property p_filt_four;
    @(posedge pclk) disable iff (!presetn)
    $changed(cur_ff.filt) |-> ($past(cur_ff.hist) == {FILT_SAMPLES{cur_ff.filt}});
  endproperty
  a_filt_four: assert property (p_filt_four) else $error("filter changed early"); // RL1

  property p_filt_delay;
    @(posedge pclk) disable iff (!presetn)
    $rose(cur_ff.filt) |-> $past(event_in, 4);
  endproperty
  a_filt_delay: assert property (p_filt_delay) else $error("filter delay wrong"); // RL2

endmodule : pte_evt_cond

// file: design/pte_top.sv
/*
  Event conditioning, interrupt flags and sync status of the waveform timer,
  with an APB slave for its five registers.
  Assumes strobes, cycle end and waveform outputs come synchronous to pclk
  from the counter logic, and that the timer side shares pclk.
*/
// Chosen here: register access over APB.
// Contract
// RL1: Filtered event level changes only after four equal consecutive samples.
// RL2: Filtering delays capture by four clock cycles versus unfiltered path.
// RL3: Asynchronous mode lets the event act on the output directly.
// RL4: Config bits 7:6: 0 neither, 1 filter, 2 asynchronous, others reserved.
// RL5: Edge bit 4: 0 falling or low, 1 rising or high triggers.
// RL6: Action bit 2: 0 fault only, 1 fault and capture.
// RL7: Fault reaction comes from the matching input mode setting.
// RL8: Bit 0 of each event control makes the event a trigger source.
// RL9: Interrupt enables: trigger B bit 3, trigger A bit 2, overflow bit 0.
// RL10: Trigger A or B flag sets on its trigger or capture condition.
// RL11: Overflow flag sets at each end of timer cycle.
// RL12: Flags clear only by writing one; writing zero keeps them.
// RL13: Activity bits 7 and 6 set when output B or A toggles.
// RL14: Software clears an activity bit by writing one before reuse.
// RL15: Command ready bit 1 reads high once last command is synced.
// RL16: Command strobes or compare B high write with auto update clear it.
// RL17: Enable ready bit 0 reads high once enable value is synced.
// RL18: Enable write, disable strobe or debug break without run clear it.
// RL19: A command issued while one is still syncing is ignored.
// RL20: Each enable write syncs; a new one is accepted only after.
// RL21: Interrupt request is high while any flag and its enable are set.
// RL22: Ready bits rise again by themselves when syncing completes.
`timescale 1ns/1ps
module pte_top
  import pte_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_in_a,
  input  wire logic        event_in_b,
  input  wire logic [3:0]  input_mode_a,
  input  wire logic [3:0]  input_mode_b,
  input  wire logic        waveform_out_a,
  input  wire logic        waveform_out_b,
  input  wire logic        cycle_end,
  input  wire logic        sync_at_cycle_end_strobe,
  input  wire logic        sync_now_strobe,
  input  wire logic        restart_strobe,
  input  wire logic        soft_capture_a_strobe,
  input  wire logic        soft_capture_b_strobe,
  input  wire logic        auto_update,
  input  wire logic        compare_b_clear_high_wr,
  input  wire logic        enable_wr,
  input  wire logic        disable_at_cycle_end_strobe,
  input  wire logic        debug_break,
  input  wire logic        debug_run,
  output logic             irq,
  output logic             trigger_a,
  output logic             trigger_b,
  output logic             capture_a,
  output logic             capture_b,
  output logic      [3:0]  fault_reaction_a,
  output logic      [3:0]  fault_reaction_b,
  output logic             async_fault_a,
  output logic             async_fault_b,
  output logic             command_taken,
  output logic             enable_taken
);

  typedef struct packed {
    logic [7:0]  evt_a;
    logic [7:0]  evt_b;
    logic [7:0]  int_en;
    logic [7:0]  flags;
    logic        act_a;
    logic        act_b;
    logic        woa_prev;
    logic        wob_prev;
    logic        brk_prev;
    logic [3:0]  fra;
    logic [3:0]  frb;
    logic [31:0] prdata;
  } pte_top_st_t;

  pte_top_st_t cur_ff;
  pte_top_st_t nxt_cur;

  logic       fault_a;
  logic       fault_b;
  logic       command_ready;
  logic       enable_ready;
  logic       cmd_start;
  logic       en_start;
  logic       brk_rise;
  logic [2:0] sel;
  logic       acc;
  logic       wr;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] status_val;

  // Byte address is four times the printed index
  function automatic logic [7:0] pte_addr(input logic [7:0] idx);
    pte_addr = {idx[5:0], 2'b00};
  endfunction : pte_addr

  function automatic logic [2:0] pte_sel(input logic [7:0] addr);
    if (addr == pte_addr(IDX_EVT_A)) begin
      pte_sel = SEL_EVT_A;
    end else if (addr == pte_addr(IDX_EVT_B)) begin
      pte_sel = SEL_EVT_B;
    end else if (addr == pte_addr(IDX_INT_EN)) begin
      pte_sel = SEL_INT_EN;
    end else if (addr == pte_addr(IDX_FLAGS)) begin
      pte_sel = SEL_FLAGS;
    end else if (addr == pte_addr(IDX_STATUS)) begin
      pte_sel = SEL_STATUS;
    end else begin
      pte_sel = SEL_NONE;
    end
  endfunction : pte_sel

  pte_evt_cond u_cond_a (
    .pclk        (pclk),
    .presetn     (presetn),
    .event_in    (event_in_a),
    .cfg         (cur_ff.evt_a),
    .trigger     (trigger_a),
    .capture     (capture_a),
    .fault       (fault_a),
    .async_fault (async_fault_a)
  );

  pte_evt_cond u_cond_b (
    .pclk        (pclk),
    .presetn     (presetn),
    .event_in    (event_in_b),
    .cfg         (cur_ff.evt_b),
    .trigger     (trigger_b),
    .capture     (capture_b),
    .fault       (fault_b),
    .async_fault (async_fault_b)
  );

  assign cmd_start = sync_at_cycle_end_strobe || sync_now_strobe || restart_strobe ||
                     soft_capture_a_strobe || soft_capture_b_strobe ||
                     (auto_update && compare_b_clear_high_wr); // RL16
  assign brk_rise  = debug_break && !cur_ff.brk_prev;
  assign en_start  = enable_wr || disable_at_cycle_end_strobe ||
                     (brk_rise && !debug_run); // RL18 RL20

  pte_sync_track u_cmd_trk (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (cmd_start),
    .ready   (command_ready),
    .taken   (command_taken)
  );

  pte_sync_track u_en_trk (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (en_start),
    .ready   (enable_ready),
    .taken   (enable_taken)
  );

  assign sel = pte_sel(paddr);
  assign acc = psel && penable;
  assign wr  = acc && pwrite && (sel != SEL_NONE);

  always_comb begin
    flag_set            = '0;
    flag_set[TRIGGER_A_IRQ_BIT] = trigger_a; // RL10
    flag_set[TRIGGER_B_IRQ_BIT] = trigger_b;
    flag_set[OVF_BIT]   = cycle_end; // RL11
    flag_clr = (wr && sel == SEL_FLAGS) ? (pwdata[7:0] & INT_MASK) : '0;
  end

  always_comb begin
    status_val             = '0;
    status_val[ACTB_BIT]   = cur_ff.act_b;
    status_val[ACTA_BIT]   = cur_ff.act_a;
    status_val[COMMAND_READY_BIT] = command_ready; // RL15
    status_val[ENABLE_READY_BIT]  = enable_ready; // RL17
  end

  always_comb begin
    nxt_cur          = cur_ff;
    nxt_cur.woa_prev = waveform_out_a;
    nxt_cur.wob_prev = waveform_out_b;
    nxt_cur.brk_prev = debug_break;
    if (wr && sel == SEL_EVT_A) begin
      nxt_cur.evt_a = pwdata[7:0] & EVT_MASK;
    end
    if (wr && sel == SEL_EVT_B) begin
      nxt_cur.evt_b = pwdata[7:0] & EVT_MASK;
    end
    if (wr && sel == SEL_INT_EN) begin
      nxt_cur.int_en = pwdata[7:0] & INT_MASK; // RL9
    end
    // Set beats a same-cycle clear so no event is lost
    nxt_cur.flags = (cur_ff.flags & ~flag_clr) | flag_set; // RL12
    if (wr && sel == SEL_STATUS && pwdata[ACTA_BIT]) begin
      nxt_cur.act_a = 1'b0;
    end
    if (wr && sel == SEL_STATUS && pwdata[ACTB_BIT]) begin
      nxt_cur.act_b = 1'b0;
    end
    if (waveform_out_a != cur_ff.woa_prev) begin
      nxt_cur.act_a = 1'b1; // RL13
    end
    if (waveform_out_b != cur_ff.wob_prev) begin
      nxt_cur.act_b = 1'b1; // RL13
    end
    nxt_cur.fra = fault_a ? input_mode_a : 4'h0; // RL7
    nxt_cur.frb = fault_b ? input_mode_b : 4'h0; // RL7
    // Read data is sampled in the setup phase for a zero-wait answer
    if (psel && !penable && !pwrite) begin
      if (sel == SEL_EVT_A) begin
        nxt_cur.prdata = {24'h000000, cur_ff.evt_a};
      end else if (sel == SEL_EVT_B) begin
        nxt_cur.prdata = {24'h000000, cur_ff.evt_b};
      end else if (sel == SEL_INT_EN) begin
        nxt_cur.prdata = {24'h000000, cur_ff.int_en};
      end else if (sel == SEL_FLAGS) begin
        nxt_cur.prdata = {24'h000000, cur_ff.flags};
      end else if (sel == SEL_STATUS) begin
        nxt_cur.prdata = {24'h000000, status_val};
      end else begin
        nxt_cur.prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff        <= '0;
      cur_ff.evt_a  <= REG_RESET;
      cur_ff.evt_b  <= REG_RESET;
      cur_ff.int_en <= REG_RESET;
      cur_ff.flags  <= REG_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata           = cur_ff.prdata;
  assign pready           = 1'b1;
  assign pslverr          = acc && (sel == SEL_NONE);
  assign irq              = |(cur_ff.flags & cur_ff.int_en); // RL21
  assign fault_reaction_a = cur_ff.fra;
  assign fault_reaction_b = cur_ff.frb;

  property p_ovf_set;
    @(posedge pclk) disable iff (!presetn)
    cycle_end |=> cur_ff.flags[OVF_BIT];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set"); // RL11

  property p_trig_set;
    @(posedge pclk) disable iff (!presetn)
    (trigger_a || trigger_b) |=>
      (!$past(trigger_a) || cur_ff.flags[TRIGGER_A_IRQ_BIT]) &&
      (!$past(trigger_b) || cur_ff.flags[TRIGGER_B_IRQ_BIT]);
  endproperty
  a_trig_set: assert property (p_trig_set) else $error("trigger flag not set"); // RL10

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
    (wr && sel == SEL_FLAGS && pwdata[OVF_BIT] && !cycle_end) |=> !cur_ff.flags[OVF_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one"); // RL12

  property p_w0_keep;
    @(posedge pclk) disable iff (!presetn)
    (wr && sel == SEL_FLAGS && !pwdata[TRIGGER_A_IRQ_BIT] && cur_ff.flags[TRIGGER_A_IRQ_BIT])
      |=> cur_ff.flags[TRIGGER_A_IRQ_BIT];
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("flag lost on zero write"); // RL12

  property p_irq_ovf;
    @(posedge pclk) disable iff (!presetn)
    (cycle_end && cur_ff.int_en[OVF_BIT]) |=> irq;
  endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("no interrupt request"); // RL21

  property p_irq_masked;
    @(posedge pclk) disable iff (!presetn)
    (cur_ff.int_en == 8'h00) |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked"); // RL9

  property p_act_a;
    @(posedge pclk) disable iff (!presetn)
    $changed(waveform_out_a) |=> ##1 cur_ff.act_a;
  endproperty
  a_act_a: assert property (p_act_a) else $error("activity A missed"); // RL13

  // Set wins over a clear, so the bit must stand on the next edge
  property p_act_b;
    @(posedge pclk) disable iff (!presetn)
    $changed(waveform_out_b) |=> cur_ff.act_b;
  endproperty
  a_act_b: assert property (p_act_b) else $error("activity B missed"); // RL13

  property p_cmd_clear;
    @(posedge pclk) disable iff (!presetn)
    (cmd_start && command_ready) |=> !command_ready ##3 command_ready;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command ready wrong"); // RL16

  property p_brk_clear;
    @(posedge pclk) disable iff (!presetn)
    ($rose(debug_break) && !debug_run && enable_ready) |=> !enable_ready;
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("enable ready not cleared"); // RL18

  property p_fault_mode;
    @(posedge pclk) disable iff (!presetn)
    fault_a |=> (fault_reaction_a == $past(input_mode_a));
  endproperty
  a_fault_mode: assert property (p_fault_mode) else $error("fault reaction wrong"); // RL7

endmodule : pte_top

// file: verif/pte_timer_model.sv
/*
  Counter-side stand-in: cycle end pulses and toggling waveform outputs.
  Assumes it shares pclk with the block; counter and waveforms hold while run is low, and cycle end stays low.
*/
`timescale 1ns/1ps
module pte_timer_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      waveform_out_a,
  output logic      waveform_out_b,
  output logic      cycle_end
);
  logic [2:0] cnt_ff;

  // Short period of eight, so a few cycles show several overflows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff         <= 3'h0;
      waveform_out_a <= 1'h0;
      waveform_out_b <= 1'h0;
      cycle_end      <= 1'h0;
    end else begin
      cycle_end <= run && (cnt_ff == 3'h7);
      if (run) begin
        cnt_ff <= cnt_ff + 3'h1;
        if (cnt_ff == 3'h2) begin
          waveform_out_a <= !waveform_out_a;
        end
        if (cnt_ff == 3'h5) begin
          waveform_out_b <= !waveform_out_b;
        end
      end
    end
  end
endmodule : pte_timer_model

// file: verif/pwm_timer_event_irq_status_test.sv
/*
  Self-checking bench for the event, flag and sync status block.
  Assumes the stand-in pte_timer_model and the zero-wait APB of pte_top.
*/
`timescale 1ns/1ps
module pwm_timer_event_irq_status_test;
  import pte_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} pte_reg_row_t;
  typedef struct {logic b; logic [7:0] cfg; int lat; logic cap;} pte_evt_row_t;
  typedef struct {logic [8:0] v; logic au; logic dr; logic c; logic n;} pte_sync_row_t;
  localparam logic [7:0] A_EVA = IDX_EVT_A << 2;
  localparam logic [7:0] A_EVB = IDX_EVT_B << 2;
  localparam logic [7:0] A_INT = IDX_INT_EN << 2;
  localparam logic [7:0] A_FLG = IDX_FLAGS << 2;
  localparam logic [7:0] A_STS = IDX_STATUS << 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        event_in_a, event_in_b, run, auto_update, debug_run, irq;
  logic [3:0]  input_mode_a, input_mode_b, fault_reaction_a, fault_reaction_b;
  logic        waveform_out_a, waveform_out_b, cycle_end;
  logic [8:0]  strb;
  logic        trigger_a, trigger_b, capture_a, capture_b;
  logic        async_fault_a, async_fault_b, command_taken, enable_taken;
  int          fail_count, total_checks, i, k;
  pte_reg_row_t rrow [9] = '{'{1'h0, A_EVA, 8'h00, 8'h00}, '{1'h0, A_EVB, 8'h00, 8'h00},
    '{1'h0, A_INT, 8'h00, 8'h00}, '{1'h0, A_FLG, 8'h00, 8'h00}, '{1'h0, A_STS, 8'h00, 8'h03},
    '{1'h1, A_EVA, 8'hFF, 8'hD5}, '{1'h1, A_EVB, 8'h51, 8'h51},
    '{1'h1, A_INT, 8'hFF, 8'h0D}, '{1'h1, A_STS, 8'h03, 8'h03}};
  pte_evt_row_t erow [7] = '{'{1'h0, 8'h15, 2, 1'h1}, '{1'h0, 8'h55, 6, 1'h1},
    '{1'h0, 8'h11, 2, 1'h0}, '{1'h0, 8'h14, 20, 1'h0}, '{1'h1, 8'h05, 2, 1'h1},
    '{1'h1, 8'h45, 6, 1'h1}, '{1'h1, 8'hC5, 2, 1'h1}};
  pte_sync_row_t srow [11] = '{'{9'h001, 1'h0, 1'h0, 1'h1, 1'h0},
    '{9'h002, 1'h0, 1'h0, 1'h1, 1'h0}, '{9'h004, 1'h0, 1'h0, 1'h1, 1'h0},
    '{9'h008, 1'h0, 1'h0, 1'h1, 1'h0}, '{9'h010, 1'h0, 1'h0, 1'h1, 1'h0},
    '{9'h020, 1'h1, 1'h0, 1'h1, 1'h0}, '{9'h020, 1'h0, 1'h0, 1'h0, 1'h0},
    '{9'h040, 1'h0, 1'h0, 1'h0, 1'h1}, '{9'h080, 1'h0, 1'h0, 1'h0, 1'h1},
    '{9'h100, 1'h0, 1'h0, 1'h0, 1'h1}, '{9'h100, 1'h0, 1'h1, 1'h0, 1'h0}};

  pte_top pte_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .event_in_a, .event_in_b, .input_mode_a, .input_mode_b,
    .waveform_out_a, .waveform_out_b, .cycle_end, .sync_at_cycle_end_strobe(strb[0]),
    .sync_now_strobe(strb[1]), .restart_strobe(strb[2]), .soft_capture_a_strobe(strb[3]),
    .soft_capture_b_strobe(strb[4]), .auto_update, .compare_b_clear_high_wr(strb[5]),
    .enable_wr(strb[6]), .disable_at_cycle_end_strobe(strb[7]), .debug_break(strb[8]),
    .debug_run, .irq, .trigger_a, .trigger_b, .capture_a, .capture_b, .fault_reaction_a,
    .fault_reaction_b, .async_fault_a, .async_fault_b, .command_taken, .enable_taken);
  pte_timer_model pte_timer_model_inst (.pclk, .presetn, .run, .waveform_out_a,
    .waveform_out_b, .cycle_end);

  always #2 pclk = ~pclk;

  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 10);
    if (pready !== 1'h1) begin
      fail_count++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'h1, a, {24'h0, d}, rd, er);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'h0, a, 32'h0, rd, er);
    chk(nm, {24'h0, e}, rd);
  endtask : rdchk

  // Latency counted from the edge that drives the active level, one edge before it is first sampled
  task automatic evt(input pte_evt_row_t r);
    int n;
    @(posedge pclk);
    if (r.b) event_in_b <= !r.cfg[4];
    else event_in_a <= !r.cfg[4];
    wr(r.b ? A_EVB : A_EVA, r.cfg);
    repeat (8) @(posedge pclk);
    if (r.b) event_in_b <= r.cfg[4];
    else event_in_a <= r.cfg[4];
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      #1;
    end while ((r.b ? trigger_b : trigger_a) !== 1'h1 && n < 20);
    chk("trigger_latency", r.lat, n);
    chk("capture", r.cap, r.b ? capture_b : capture_a);
    @(posedge pclk);
    #1;
    chk("fault_reaction", r.cfg[0] ? (r.b ? 4'h5 : 4'hA) : 4'h0,
        r.b ? fault_reaction_b : fault_reaction_a);
    @(posedge pclk);
    if (r.b) event_in_b <= !r.cfg[4];
    else event_in_a <= !r.cfg[4];
  endtask : evt

  task automatic sync_row(input pte_sync_row_t r);
    @(posedge pclk);
    auto_update <= r.au;
    debug_run   <= r.dr;
    @(posedge pclk);
    strb <= r.v;
    @(posedge pclk);
    strb <= 9'h000;
    #1;
    chk("command_taken", r.c, command_taken);
    chk("enable_taken", r.n, enable_taken);
    if (r.c || r.n) begin
      @(posedge pclk);
      strb <= r.v;
      @(posedge pclk);
      strb <= 9'h000;
      #1;
      chk("busy_refused", 2'h0, {command_taken, enable_taken});
    end
    repeat (6) @(posedge pclk);
    rdchk("ready_back", A_STS, 8'h03);
  endtask : sync_row

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {event_in_a, event_in_b, run, auto_update, debug_run, strb} = '0;
    input_mode_a = 4'hA;
    input_mode_b = 4'h5;
    fail_count   = 0;
    total_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    for (i = 0; i < 9; i++) begin
      if (rrow[i].wr) wr(rrow[i].a, rrow[i].d);
      rdchk("register", rrow[i].a, rrow[i].e);
    end
    begin : unmapped
      logic [31:0] rd;
      logic        er;
      apb(1'h0, 8'h3C, 32'h0, rd, er);
      chk("unmapped_read", 32'h0, rd);
      chk("unmapped_pslverr", 1'h1, er);
    end
    wr(A_FLG, 8'hFF);
    for (i = 0; i < 7; i++) evt(erow[i]);
    rdchk("flags_trig", A_FLG, 8'h0C);
    chk("irq_on", 1'h1, irq);
    wr(A_FLG, 8'h00);
    rdchk("flags_zero_write", A_FLG, 8'h0C);
    wr(A_FLG, 8'h04);
    rdchk("flags_clear_a", A_FLG, 8'h08);
    wr(A_FLG, 8'h08);
    #1;
    chk("irq_off", 1'h0, irq);
    // Three equal samples must not move the filtered level
    wr(A_EVA, 8'h55);
    repeat (8) @(posedge pclk);
    event_in_a <= 1'h1;
    repeat (3) @(posedge pclk);
    event_in_a <= 1'h0;
    k = 0;
    repeat (12) begin
      @(posedge pclk);
      #1;
      if (trigger_a !== 1'h0) k++;
    end
    chk("filter_glitch", 0, k);
    wr(A_EVB, 8'h81);
    wr(A_EVA, 8'h91);
    @(posedge pclk);
    event_in_a <= 1'h1;
    event_in_b <= 1'h0;
    #1;
    chk("async_on", 1'h1, async_fault_a);
    chk("async_b_on", 1'h1, async_fault_b);
    @(posedge pclk);
    event_in_a <= 1'h0;
    #1;
    chk("async_off", 1'h0, async_fault_a);
    wr(A_FLG, 8'hFF);
    @(posedge pclk);
    run <= 1'h1;
    repeat (20) @(posedge pclk);
    run <= 1'h0;
    rdchk("flags_ovf", A_FLG, 8'h01);
    rdchk("activity", A_STS, 8'hC3);
    wr(A_STS, 8'h00);
    rdchk("activity_kept", A_STS, 8'hC3);
    wr(A_STS, 8'hC0);
    rdchk("activity_clr", A_STS, 8'h03);
    for (i = 0; i < 11; i++) sync_row(srow[i]);
    chk("irq_ovf", 1'h1, irq);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    #1;
    chk("irq_reset", 1'h0, irq);
    @(posedge pclk);
    presetn <= 1'h1;
    rdchk("flags_reset", A_FLG, 8'h00);
    rdchk("int_en_reset", A_INT, 8'h00);
    end_of_test();
  end
endmodule : pwm_timer_event_irq_status_test
